// ### src/wsrl_pkg.sv
// Shared constants of the window supervisor reset logic
package wsrl_pkg;
	localparam int unsigned CLOCK_MHZ = 200;
	localparam int unsigned NUM_CHANNELS = 4;
	// Fault qualification delay, longest, in ns
	localparam int unsigned QUAL_DELAY_NS = 10000;
	localparam int unsigned QUAL_CYCLES = (QUAL_DELAY_NS * CLOCK_MHZ) / 1000;
	// Release delay options, in us
	localparam int unsigned RELEASE_MIN_US = 20;
	localparam int unsigned RELEASE_MAX_US = 1200000;
	localparam int unsigned RELEASE_DEFAULT_CYCLES = RELEASE_MIN_US * CLOCK_MHZ;
	// Startup delay, in us
	localparam int unsigned STARTUP_DELAY_US = 300;
	localparam int unsigned STARTUP_CYCLES = STARTUP_DELAY_US * CLOCK_MHZ;
	localparam int unsigned CNT_WIDTH = 32;
	localparam int unsigned SYNC_STAGES = 2;
	localparam int unsigned CFG_WIDTH = 8;
	localparam int unsigned UNLOCK_KEY_WIDTH = 16;
	// Arbitrary key values for the two-key unlock
	localparam logic [15:0] UNLOCK_KEY_A = 16'h5a3c;
	localparam logic [15:0] UNLOCK_KEY_B = 16'hc3a5;
	localparam logic [0:0] LOCK_RESET = 1'h0;
	typedef enum logic [2:0] {
		WSRL_ST_START_DELAY,
		WSRL_ST_CHECKSUM,
		WSRL_ST_LATCH_LOAD,
		WSRL_ST_ACTIVE,
		WSRL_ST_CHECK_FAIL
	} wsrl_state_type;
	typedef enum logic [1:0] {
		WSRL_UL_IDLE,
		WSRL_UL_KEY_A,
		WSRL_UL_OPEN
	} wsrl_unlock_type;
endpackage

// ### src/wsrl_qualifier.sv
// Synchroniser and persistence counter for one comparator result
`timescale 1ns/1ps
`default_nettype none
module wsrl_qualifier #(
	parameter int unsigned QUAL_CYCLES = wsrl_pkg::QUAL_CYCLES
) (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rst,
	// Comparator result, asynchronous
	input wire logic i_raw,
	// Qualified fault level
	output logic o_fault
);
	localparam int unsigned QW = $clog2(QUAL_CYCLES + 1);
	localparam logic [QW-1:0] QMAX = QW'(QUAL_CYCLES - 1);
	logic sync1_q;
	logic sync2_q;
	logic [QW-1:0] count_q;
	logic fault_q;

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			sync1_q <= 1'h0;
			sync2_q <= 1'h0;
		end else begin
			sync1_q <= i_raw;
			sync2_q <= sync1_q;
		end
	end

	// Fault is set when the excursion persists; short glitches restart the count
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			count_q <= '0;
			fault_q <= 1'h0;
		end else if (!sync2_q) begin
			count_q <= '0;
			fault_q <= 1'h0;
		end else if (count_q >= QMAX) begin
			fault_q <= 1'h1;
		end else begin
			count_q <= count_q + QW'(1);
		end
	end

	assign o_fault = fault_q;
endmodule
`default_nettype wire

// ### src/wsrl_release_timer.sv
// Release delay timer that stretches one channel's fault
`timescale 1ns/1ps
`default_nettype none
module wsrl_release_timer #(
	parameter int unsigned RELEASE_CYCLES = wsrl_pkg::RELEASE_DEFAULT_CYCLES
) (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rst,
	// Hold request: fault or not yet active
	input wire logic i_hold,
	// Asserted while reset must stay low
	output logic o_asserted
);
	localparam logic [31:0] RMAX = 32'(RELEASE_CYCLES - 1);
	logic [31:0] count_q;
	logic asserted_q;

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			count_q <= '0;
			asserted_q <= 1'h1;
		end else if (i_hold) begin
			count_q <= '0;
			asserted_q <= 1'h1;
		end else if (asserted_q) begin
			if (count_q >= RMAX) begin
				asserted_q <= 1'h0;
			end else begin
				count_q <= count_q + 32'h1;
			end
		end
	end

	assign o_asserted = asserted_q;
endmodule
`default_nettype wire

// ### src/wsrl_top.sv
// Reset and fault reporting logic of a window voltage supervisor
`timescale 1ns/1ps
`default_nettype none
// Contract
// - A channel's reset asserts whenever its rail is outside the window.
// - After the rail returns, reset stays asserted for the full release delay.
// - Each reset output is active low open drain, pulling low only.
// - In paired mode the shared reset asserts when either paired input faults.
// - Configuration writes open only after a two-key unlock; anything else keeps them shut.
// - After programming, lock bits block rewrites and a checksum bit is stored.
// - Undervoltage reset asserts when the rail stays low longer than the detection delay.
// - Overvoltage reset asserts when the rail stays high longer than the detection delay.
// - The checksum is verified at startup before the configuration is latched.
// - On checksum mismatch the resets are never released in that startup.
// - During startup all resets are asserted until the active state is reached.
// - The qualification delay from excursion to assertion is at most 10 us.
// - At power-up release follows the startup delay plus the release delay.
// - The release delay is a fixed factory option from 20 us to 1200 ms.
module wsrl_top #(
	parameter int unsigned NUM_CHANNELS = wsrl_pkg::NUM_CHANNELS,
	parameter int unsigned QUAL_CYCLES = wsrl_pkg::QUAL_CYCLES,
	parameter int unsigned RELEASE_CYCLES = wsrl_pkg::RELEASE_DEFAULT_CYCLES,
	parameter int unsigned STARTUP_CYCLES = wsrl_pkg::STARTUP_CYCLES,
	parameter bit PAIRED_MODE = 1'b0
) (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rst,
	// Window comparator results per rail
	input wire logic [NUM_CHANNELS-1:0] i_rail_sense_in_low,
	input wire logic [NUM_CHANNELS-1:0] i_rail_sense_in_high,
	// Stored configuration image
	input wire logic [NUM_CHANNELS*wsrl_pkg::CFG_WIDTH-1:0] i_cfg_image,
	input wire logic i_cfg_checksum,
	// Programming port
	input wire logic i_key_valid,
	input wire logic [wsrl_pkg::UNLOCK_KEY_WIDTH-1:0] i_key,
	input wire logic i_prog_done,
	// Reset pins, open drain: enable low means pulling low
	output logic [NUM_CHANNELS-1:0] o_channel_fault_out_n,
	output logic [NUM_CHANNELS-1:0] o_channel_fault_oe_n,
	// Fault flags
	output logic [NUM_CHANNELS-1:0] o_undervoltage_fault_out,
	output logic [NUM_CHANNELS-1:0] o_overvoltage_fault_out,
	// Configuration and status
	output logic [NUM_CHANNELS*wsrl_pkg::CFG_WIDTH-1:0] o_low_threshold_setting,
	output logic o_write_enable,
	output logic o_lock,
	output logic o_checksum_stored,
	output logic o_active,
	output logic o_checksum_fail
);
	localparam int unsigned CW = NUM_CHANNELS * wsrl_pkg::CFG_WIDTH;
	localparam logic [31:0] SMAX = 32'(STARTUP_CYCLES - 1);

	wsrl_pkg::wsrl_state_type state_q;
	wsrl_pkg::wsrl_unlock_type unlock_q;
	logic [31:0] start_count_q;
	logic [CW-1:0] latched_q;
	logic write_enable_q;
	logic lock_q;
	logic checksum_q;
	logic [NUM_CHANNELS-1:0] uv_fault;
	logic [NUM_CHANNELS-1:0] ov_fault;
	logic [NUM_CHANNELS-1:0] chan_fault;
	logic [NUM_CHANNELS-1:0] asserted;
	logic [NUM_CHANNELS-1:0] uv_q;
	logic [NUM_CHANNELS-1:0] ov_q;
	logic [NUM_CHANNELS-1:0] pin_q;

	// Even parity of the image must match the stored bit
	function automatic logic parity_of(input logic [CW-1:0] img);
		parity_of = ^img;
	endfunction

	// Startup sequence; a mismatch parks the device with resets held
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			state_q <= wsrl_pkg::WSRL_ST_START_DELAY;
			start_count_q <= '0;
		end else begin
			case (state_q)
				wsrl_pkg::WSRL_ST_START_DELAY: begin
					if (start_count_q >= SMAX) begin
						state_q <= wsrl_pkg::WSRL_ST_CHECKSUM;
					end else begin
						start_count_q <= start_count_q + 32'h1;
					end
				end
				wsrl_pkg::WSRL_ST_CHECKSUM: begin
					if (parity_of(i_cfg_image) == i_cfg_checksum) begin
						state_q <= wsrl_pkg::WSRL_ST_LATCH_LOAD;
					end else begin
						state_q <= wsrl_pkg::WSRL_ST_CHECK_FAIL;
					end
				end
				wsrl_pkg::WSRL_ST_LATCH_LOAD: begin
					state_q <= wsrl_pkg::WSRL_ST_ACTIVE;
				end
				wsrl_pkg::WSRL_ST_ACTIVE: begin
					state_q <= wsrl_pkg::WSRL_ST_ACTIVE;
				end
				wsrl_pkg::WSRL_ST_CHECK_FAIL: begin
					state_q <= wsrl_pkg::WSRL_ST_CHECK_FAIL;
				end
				default: begin
					state_q <= wsrl_pkg::WSRL_ST_CHECK_FAIL;
				end
			endcase
		end
	end

	// Latch load only after a good checksum
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			latched_q <= '0;
		end else if (state_q == wsrl_pkg::WSRL_ST_LATCH_LOAD) begin
			latched_q <= i_cfg_image;
		end
	end

	// Two-key unlock; a wrong key or a gap closes the sequence again
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			unlock_q <= wsrl_pkg::WSRL_UL_IDLE;
		end else if (lock_q) begin
			unlock_q <= wsrl_pkg::WSRL_UL_IDLE;
		end else begin
			case (unlock_q)
				wsrl_pkg::WSRL_UL_IDLE: begin
					if (i_key_valid && i_key == wsrl_pkg::UNLOCK_KEY_A) begin
						unlock_q <= wsrl_pkg::WSRL_UL_KEY_A;
					end
				end
				wsrl_pkg::WSRL_UL_KEY_A: begin
					if (i_key_valid && i_key == wsrl_pkg::UNLOCK_KEY_B) begin
						unlock_q <= wsrl_pkg::WSRL_UL_OPEN;
					end else begin
						unlock_q <= wsrl_pkg::WSRL_UL_IDLE;
					end
				end
				wsrl_pkg::WSRL_UL_OPEN: begin
					unlock_q <= wsrl_pkg::WSRL_UL_OPEN;
				end
				default: begin
					unlock_q <= wsrl_pkg::WSRL_UL_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			write_enable_q <= 1'h0;
		end else begin
			write_enable_q <= (unlock_q == wsrl_pkg::WSRL_UL_OPEN) && !lock_q;
		end
	end

	// Lock is sticky until power cycle; the checksum bit is kept with it
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			lock_q <= wsrl_pkg::LOCK_RESET;
			checksum_q <= 1'h0;
		end else if (write_enable_q && i_prog_done) begin
			lock_q <= 1'h1;
			checksum_q <= parity_of(i_cfg_image);
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_CHANNELS; g++) begin : gen_chan
			wsrl_qualifier #(
				.QUAL_CYCLES(QUAL_CYCLES)
			) u_uv (
				.i_clock(i_clock),
				.i_rst(i_rst),
				.i_raw(i_rail_sense_in_low[g]),
				.o_fault(uv_fault[g])
			);
			wsrl_qualifier #(
				.QUAL_CYCLES(QUAL_CYCLES)
			) u_ov (
				.i_clock(i_clock),
				.i_rst(i_rst),
				.i_raw(i_rail_sense_in_high[g]),
				.o_fault(ov_fault[g])
			);
			if (PAIRED_MODE) begin : gen_pair
				// Both rails of a pair drive the shared output
				assign chan_fault[g] = uv_fault[g] | ov_fault[g] |
					uv_fault[g ^ 1] | ov_fault[g ^ 1];
			end else begin : gen_single
				assign chan_fault[g] = uv_fault[g] | ov_fault[g];
			end
			wsrl_release_timer #(
				.RELEASE_CYCLES(RELEASE_CYCLES)
			) u_rel (
				.i_clock(i_clock),
				.i_rst(i_rst),
				.i_hold(chan_fault[g] || state_q != wsrl_pkg::WSRL_ST_ACTIVE),
				.o_asserted(asserted[g])
			);
		end
	endgenerate

	// Output flops; pin is driven low (enable low) while asserted
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			uv_q <= '0;
			ov_q <= '0;
			// Pins start asserted so every reset is held low through startup
			pin_q <= '1;
		end else begin
			uv_q <= uv_fault;
			ov_q <= ov_fault;
			pin_q <= asserted;
		end
	end

	assign o_channel_fault_out_n = '0;
	assign o_channel_fault_oe_n = ~pin_q;
	assign o_undervoltage_fault_out = uv_q;
	assign o_overvoltage_fault_out = ov_q;
	assign o_low_threshold_setting = latched_q;
	assign o_write_enable = write_enable_q;
	assign o_lock = lock_q;
	assign o_checksum_stored = checksum_q;
	assign o_active = (state_q == wsrl_pkg::WSRL_ST_ACTIVE);
	assign o_checksum_fail = (state_q == wsrl_pkg::WSRL_ST_CHECK_FAIL);
endmodule
`default_nettype wire

// ### verif/wsrl_top_checker.sv
// Concurrent checks on the ports of the supervisor reset logic
`timescale 1ns/1ps
`default_nettype none
module wsrl_top_checker #(
	parameter int unsigned NUM_CHANNELS = 4,
	parameter int unsigned RELEASE_CYCLES = 8
) (
	// Clock, reset and inputs
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic [NUM_CHANNELS-1:0] i_rail_sense_in_low,
	input wire logic [NUM_CHANNELS-1:0] i_rail_sense_in_high,
	input wire logic i_key_valid,
	input wire logic [wsrl_pkg::UNLOCK_KEY_WIDTH-1:0] i_key,
	// Outputs watched
	input wire logic [NUM_CHANNELS-1:0] o_channel_fault_out_n,
	input wire logic [NUM_CHANNELS-1:0] o_channel_fault_oe_n,
	input wire logic [NUM_CHANNELS-1:0] o_undervoltage_fault_out,
	input wire logic [NUM_CHANNELS-1:0] o_overvoltage_fault_out,
	input wire logic o_write_enable,
	input wire logic o_lock,
	input wire logic o_active,
	input wire logic o_checksum_fail
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);
	wire logic [NUM_CHANNELS-1:0] faults = o_undervoltage_fault_out | o_overvoltage_fault_out;
	sequence s_key_pair;
		i_key_valid && i_key == wsrl_pkg::UNLOCK_KEY_A && !o_lock
		##1 i_key_valid && i_key == wsrl_pkg::UNLOCK_KEY_B;
	endsequence
	sequence s_low_held;
		(o_active && i_rail_sense_in_low[0]) [*8];
	endsequence
	chk_pin_drives_low: assert property (o_channel_fault_out_n == '0)
		else $error("reset pin value not low");
	chk_startup_held: assert property (!o_active |-> o_channel_fault_oe_n == '0)
		else $error("reset released before active");
	chk_fail_held: assert property (o_checksum_fail |-> o_channel_fault_oe_n == '0 && !o_active)
		else $error("reset released after checksum mismatch");
	chk_fault_pulls_pin: assert property (faults != '0 |-> ##[0:3] (faults & o_channel_fault_oe_n) == '0)
		else $error("fault without pin asserted");
	chk_release_quiet: assert property ($rose(o_channel_fault_oe_n[0])
		|-> $past(faults[0], RELEASE_CYCLES) == 1'b0 && !faults[0])
		else $error("pin released before release delay");
	chk_uv_qualified: assert property (s_low_held |-> ##[0:4] o_undervoltage_fault_out[0])
		else $error("undervoltage not flagged");
	chk_ov_qualified: assert property ((o_active && i_rail_sense_in_high[1]) [*8]
		|-> ##[0:4] o_overvoltage_fault_out[1])
		else $error("overvoltage not flagged");
	chk_flag_has_cause: assert property ($rose(o_undervoltage_fault_out[0])
		|-> $past(i_rail_sense_in_low[0], 4))
		else $error("flag without input");
	chk_unlock_open: assert property (s_key_pair |-> ##2 o_write_enable)
		else $error("write enable not opened");
	chk_unlock_cause: assert property ($rose(o_write_enable)
		|-> $past(i_key_valid, 2) && $past(i_key, 2) == wsrl_pkg::UNLOCK_KEY_B)
		else $error("write enable without key pair");
	chk_lock_closes: assert property (o_lock |-> ##1 (o_lock && !o_write_enable))
		else $error("lock not sticky or writes open");
endmodule
bind wsrl_top wsrl_top_checker #(.NUM_CHANNELS(NUM_CHANNELS), .RELEASE_CYCLES(RELEASE_CYCLES)) u_chk (
	.i_clock, .i_rst, .i_rail_sense_in_low, .i_rail_sense_in_high, .i_key_valid, .i_key,
	.o_channel_fault_out_n, .o_channel_fault_oe_n, .o_undervoltage_fault_out,
	.o_overvoltage_fault_out, .o_write_enable, .o_lock, .o_active, .o_checksum_fail);
`default_nettype wire

// ### verif/wsrl_host_model.sv
// Host that watches the reset pins at startup
`timescale 1ns/1ps
`default_nettype none
module wsrl_host_model #(
	parameter int unsigned LIMIT = 64
) (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rst,
	// Pin levels after the pull-up
	input wire logic [3:0] i_pin_n,
	// Startup verdict
	output logic o_seen_low,
	output logic o_released,
	output logic o_late
);
	logic [15:0] wait_q;
	// Missing assertion leaves released low, so both flags must be read
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			wait_q <= '0;
			o_seen_low <= 1'b0;
			o_released <= 1'b0;
			o_late <= 1'b0;
		end else if (!o_released) begin
			wait_q <= wait_q + 16'h1;
			if (i_pin_n != 4'hf) o_seen_low <= 1'b1;
			if (i_pin_n == 4'hf && o_seen_low) o_released <= 1'b1;
			if (wait_q == LIMIT[15:0]) o_late <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// ### verif/wsrl_top_tb.sv
// Self-checking bench of the supervisor reset logic
`timescale 1ns/1ps
`default_nettype none
module wsrl_top_tb;
	localparam int unsigned RC = 8;
	localparam int unsigned SC = 8;
	localparam logic [15:0] KA = wsrl_pkg::UNLOCK_KEY_A;
	localparam logic [15:0] KB = wsrl_pkg::UNLOCK_KEY_B;
	logic i_clock = 1'b0;
	logic i_rst = 1'b1;
	logic [3:0] low = '0;
	logic [3:0] high = '0;
	logic [31:0] image = 32'h00000003;
	logic csum = 1'b0;
	logic kv = 1'b0;
	logic [15:0] key = '0;
	logic done = 1'b0;
	wire logic [3:0] out_n, oe_n, uv, ov;
	wire logic [3:0] oe_pair;
	wire logic [31:0] thr;
	wire logic we, lock, stored, active, cfail, seen, rel, late;
	int n_errors = 0;
	int check_count = 0;
	always #2.5 i_clock = ~i_clock;
	wsrl_top #(.QUAL_CYCLES(4), .RELEASE_CYCLES(RC), .STARTUP_CYCLES(SC)) DUT (
		.i_clock(i_clock), .i_rst(i_rst), .i_rail_sense_in_low(low), .i_rail_sense_in_high(high),
		.i_cfg_image(image), .i_cfg_checksum(csum), .i_key_valid(kv), .i_key(key),
		.i_prog_done(done), .o_channel_fault_out_n(out_n), .o_channel_fault_oe_n(oe_n),
		.o_undervoltage_fault_out(uv), .o_overvoltage_fault_out(ov),
		.o_low_threshold_setting(thr), .o_write_enable(we), .o_lock(lock),
		.o_checksum_stored(stored), .o_active(active), .o_checksum_fail(cfail));
	// Paired variant on the same stimulus: a fault on either rail of a pair pulls both pins
	wsrl_top #(.QUAL_CYCLES(4), .RELEASE_CYCLES(RC), .STARTUP_CYCLES(SC), .PAIRED_MODE(1'b1)) DUT_PAIR (
		.i_clock(i_clock), .i_rst(i_rst), .i_rail_sense_in_low(low), .i_rail_sense_in_high(high),
		.i_cfg_image(image), .i_cfg_checksum(csum), .i_key_valid(kv), .i_key(key),
		.i_prog_done(done), .o_channel_fault_out_n(), .o_channel_fault_oe_n(oe_pair),
		.o_undervoltage_fault_out(), .o_overvoltage_fault_out(), .o_low_threshold_setting(),
		.o_write_enable(), .o_lock(), .o_checksum_stored(), .o_active(), .o_checksum_fail());
	// Pull-up: a released pin reads high
	wsrl_host_model #(.LIMIT(SC + RC + 16)) u_host (.i_clock(i_clock), .i_rst(i_rst),
		.i_pin_n(oe_n | out_n), .o_seen_low(seen), .o_released(rel), .o_late(late));
	task automatic report_and_stop;
		$display("Checks %0d, errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic check_vec(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge i_clock);
		#1;
	endtask
	task automatic wait_pins(input logic [3:0] exp, output int n);
		n = 0;
		while (oe_n !== exp && n < 200) begin
			tick(1);
			n++;
		end
	endtask
	task automatic send_keys(input logic [15:0] a, input logic [15:0] b);
		kv = 1'b1;
		key = a;
		tick(1);
		key = b;
		tick(1);
		kv = 1'b0;
		tick(4);
	endtask
	task automatic rail_fault(input int ch, input bit ovs);
		int n;
		for (int k = 0; k < 2; k++) begin
			if (ovs) high[ch] = 1'b1;
			else low[ch] = 1'b1;
			if (k == 0) begin
				tick(2);
				high = '0;
				low = '0;
				tick(10);
				check_vec({uv, ov}, 8'h00);
			end
		end
		wait_pins(~(4'h1 << ch), n);
		check_vec(n <= 12, 1);
		check_vec({28'h0, ~(4'h3 << (ch & 2))}, oe_pair);
		tick(10);
		check_vec({uv, ov}, (ovs ? 8'h01 : 8'h10) << ch);
		high = '0;
		low = '0;
		wait_pins(4'hf, n);
		check_vec(n >= RC, 1);
	endtask
	initial begin
		int n;
		tick(16);
		i_rst = 1'b0;
		check_vec(oe_n, 4'h0);
		n = 0;
		while (active !== 1'b1 && n < 100) begin
			tick(1);
			n++;
		end
		check_vec(n >= SC, 1);
		check_vec(thr, image);
		wait_pins(4'hf, n);
		check_vec(n >= RC, 1);
		// The host registers the release one edge after the pins go high
		tick(1);
		check_vec({seen, rel, late}, 3'b110);
		rail_fault(0, 1'b0);
		rail_fault(1, 1'b1);
		send_keys(KB, KA);
		check_vec(we, 1'b0);
		send_keys(KA, KB);
		check_vec(we, 1'b1);
		// Odd parity image, so the stored bit differs from its reset value
		image = 32'h00000007;
		done = 1'b1;
		tick(1);
		done = 1'b0;
		tick(2);
		check_vec({lock, we, stored}, 3'b101);
		send_keys(KA, KB);
		check_vec(we, 1'b0);
		i_rst = 1'b1;
		csum = 1'b1;
		image = 32'h00000003;
		tick(2);
		i_rst = 1'b0;
		tick(SC + RC + 40);
		check_vec({cfail, active, oe_n}, 6'b100000);
		report_and_stop();
	end
	// Whole run is well under 1000 cycles
	initial begin
		#10000;
		n_errors++;
		$display("ERROR %0t: timeout", $time);
		report_and_stop();
	end
endmodule
`default_nettype wire
